/* File: hw/pot_link_slave.sv */
`timescale 1ns/10ps
// What this block does
// - Data changes while the clock is high are taken as start or stop.
// - Device is slave only; the master supplies every clock.
// - Start is data falling with clock high; nothing happens before one.
// - Stop is data rising with clock high.
// - Address upper nibble must equal the fixed device type code.
// - Address lower nibble must equal the four strap pins.
// - Acknowledge the address byte only on a full match.
// - Receiver pulls data low on the ninth clock to acknowledge.
// - When written, acknowledge every received byte except guarded nonvolatile write data.
// - In read mode send eight bits, release, sample the master acknowledge.
// - On a missing master acknowledge stop sending and wait for stop.
// - Stop after a nonvolatile write starts programming; requests ignored meanwhile.
// - Programming lasts at most five milliseconds from the stop.
// - While programming, data stays released and address is not acknowledged.
// - Polling address gets no acknowledge while busy, acknowledge once done.
// - Write guard pin low makes nonvolatile registers read only.
// - Guard falling after start cancels the write; after programming starts, no effect.
// - Guarded: acknowledge address and instruction, withhold acknowledge of nonvolatile write data.
// - Instruction byte: opcode, two register select bits, two pot select bits.
module pot_link_slave #(
   // Value is arbitrary; set it to the part's device type code
   parameter logic [3:0] DEVICE_TYPE_ID = 4'hA,
   parameter int NV_CYCLES = pot_if_pkg::NV_PROGRAM_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic strap_addr_bit3,
   input wire logic strap_addr_bit2,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit0,
   input wire logic wp_n,
   input wire logic [7:0] rd_data,
   output logic rd_req,
   output pot_if_pkg::pot_cmd_t cmd,
   output logic cmd_valid,
   output logic nv_busy
);
   localparam int CW = $clog2(NV_CYCLES + 1);

   logic samp_bit;
   logic samp_tog;
   logic [3:0] sync_s;
   logic scl_s;
   logic sda_s;
   logic wp_n_s;
   logic tog_s;
   logic scl_prev_q;
   logic sda_prev_q;
   logic tog_seen_q;
   logic scl_fall;
   logic start_evt;
   logic stop_evt;
   logic bit_evt;
   pot_if_pkg::link_state_t state_q;
   pot_if_pkg::link_state_t after_ack_q;
   pot_if_pkg::link_state_t after_d;
   logic [3:0] cnt_q;
   logic [6:0] shift_q;
   logic [7:0] byte_in;
   logic byte_done;
   logic ack_d;
   logic ack_pend_q;
   logic [7:0] tx_q;
   logic tx_load;
   logic drive_low_q;
   pot_if_pkg::instr_t instr_q;
   logic [7:0] data_q;
   logic pend_q;
   logic guard_q;
   logic busy_q;
   logic [CW-1:0] busy_cnt_q;
   logic addr_match;
   logic nv_blocked;

   // Link-clock side: captures each bit on the master's clock
   scl_bit_sampler u_sampler (
      .scl(scl),
      .resetn(resetn),
      .sda_i(sda_i),
      .bit_q(samp_bit),
      .bit_tog_q(samp_tog)
   );

   // Pins and the bit toggle brought into the reference domain
   sync2 #(
      .WIDTH(4),
      .RESET_VAL(pot_if_pkg::SYNC_RESET)
   ) u_sync (
      .clk(ref_clk),
      .resetn(resetn),
      .d({scl, sda_i, wp_n, samp_tog}),
      .q(sync_s)
   );

   assign scl_s = sync_s[3];
   assign sda_s = sync_s[2];
   assign wp_n_s = sync_s[1];
   assign tog_s = sync_s[0];

   // Previous levels for edge detection, all taken after the synchroniser
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         tog_seen_q <= 1'b0;
      end
      else
      begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         tog_seen_q <= tog_s;
      end
   end

   // Bus conditions; data moving under a high clock is never a data bit
   assign scl_fall = scl_prev_q & ~scl_s;
   assign start_evt = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_evt = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   // The sampled bit is held a whole clock period, so it is stable once the toggle lands
   assign bit_evt = tog_s ^ tog_seen_q;

   assign byte_in = {shift_q, samp_bit};
   assign byte_done = bit_evt && (cnt_q == pot_if_pkg::BIT_LAST_DATA)
      && ((state_q == pot_if_pkg::ST_ADDR) || (state_q == pot_if_pkg::ST_INSTR)
      || (state_q == pot_if_pkg::ST_DATA));

   // Full eight-bit address match; a busy device answers nobody
   assign addr_match = (byte_in[7:4] == DEVICE_TYPE_ID)
      && (byte_in[3:0] == {strap_addr_bit3, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0})
      && !busy_q;

   // Guarded nonvolatile targets may not be programmed
   assign nv_blocked = guard_q && pot_if_pkg::is_nv_write(instr_q.opcode);

   // Acknowledge decision and next state at the end of each received byte
   always_comb
   begin
      ack_d = 1'b0;
      after_d = pot_if_pkg::ST_WAIT_STOP;
      unique case (state_q)
         pot_if_pkg::ST_ADDR:
         begin
            ack_d = addr_match;
            after_d = addr_match ? pot_if_pkg::ST_INSTR : pot_if_pkg::ST_WAIT_STOP;
         end
         pot_if_pkg::ST_INSTR:
         begin
            // Instruction is acknowledged even when guarded
            ack_d = 1'b1;
            if (pot_if_pkg::is_read(byte_in[7:4]))
            begin
               after_d = pot_if_pkg::ST_TX;
            end
            else if (pot_if_pkg::is_data_write(byte_in[7:4]))
            begin
               after_d = pot_if_pkg::ST_DATA;
            end
            else
            begin
               after_d = pot_if_pkg::ST_WAIT_STOP;
            end
         end
         pot_if_pkg::ST_DATA:
         begin
            ack_d = !nv_blocked;
            after_d = pot_if_pkg::ST_WAIT_STOP;
         end
         default:
         begin
            ack_d = 1'b0;
            after_d = pot_if_pkg::ST_WAIT_STOP;
         end
      endcase
   end

   // Byte framing; a start restarts from any state, a stop always ends the frame
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         state_q <= pot_if_pkg::ST_IDLE;
         after_ack_q <= pot_if_pkg::ST_IDLE;
         cnt_q <= pot_if_pkg::BIT_FIRST;
         shift_q <= '0;
         ack_pend_q <= 1'b0;
      end
      else if (start_evt)
      begin
         state_q <= pot_if_pkg::ST_ADDR;
         cnt_q <= pot_if_pkg::BIT_FIRST;
         ack_pend_q <= 1'b0;
      end
      else if (stop_evt)
      begin
         state_q <= pot_if_pkg::ST_IDLE;
         cnt_q <= pot_if_pkg::BIT_FIRST;
         ack_pend_q <= 1'b0;
      end
      else if (bit_evt)
      begin
         unique case (state_q)
            pot_if_pkg::ST_ADDR, pot_if_pkg::ST_INSTR, pot_if_pkg::ST_DATA:
            begin
               if (cnt_q == pot_if_pkg::BIT_ACK)
               begin
                  // Ninth clock done; move on to the byte decided earlier
                  cnt_q <= pot_if_pkg::BIT_FIRST;
                  ack_pend_q <= 1'b0;
                  state_q <= after_ack_q;
               end
               else
               begin
                  shift_q <= byte_in[6:0];
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == pot_if_pkg::BIT_LAST_DATA)
                  begin
                     ack_pend_q <= ack_d;
                     after_ack_q <= after_d;
                  end
               end
            end
            pot_if_pkg::ST_TX:
            begin
               if (cnt_q == pot_if_pkg::BIT_ACK)
               begin
                  cnt_q <= pot_if_pkg::BIT_FIRST;
                  // Keep sending on acknowledge, else go quiet until stop
                  if (samp_bit != pot_if_pkg::SDA_ACK_LEVEL)
                  begin
                     state_q <= pot_if_pkg::ST_WAIT_STOP;
                  end
               end
               else
               begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            pot_if_pkg::ST_IDLE, pot_if_pkg::ST_WAIT_STOP:
            begin
               // Bits outside a selected frame are ignored
               cnt_q <= cnt_q;
            end
            default:
            begin
               state_q <= pot_if_pkg::ST_WAIT_STOP;
            end
         endcase
      end
   end

   // Read data is latched as the first byte starts and again after each acknowledge
   assign tx_load = bit_evt && (cnt_q == pot_if_pkg::BIT_ACK)
      && (((state_q == pot_if_pkg::ST_INSTR) && (after_ack_q == pot_if_pkg::ST_TX))
      || ((state_q == pot_if_pkg::ST_TX) && (samp_bit == pot_if_pkg::SDA_ACK_LEVEL)));

   // Transmit shifter; moves on the falling clock that puts each bit out
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         tx_q <= pot_if_pkg::BYTE_RESET;
      end
      else if (tx_load)
      begin
         tx_q <= rd_data;
      end
      else if (scl_fall && (state_q == pot_if_pkg::ST_TX) && (cnt_q != pot_if_pkg::BIT_ACK))
      begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // Line drive changes only while the clock is low, except the release forced by a start or stop
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         drive_low_q <= 1'b0;
      end
      else if (start_evt || stop_evt)
      begin
         drive_low_q <= 1'b0;
      end
      else if (scl_fall)
      begin
         if (ack_pend_q && (cnt_q == pot_if_pkg::BIT_ACK))
         begin
            drive_low_q <= 1'b1;
         end
         else if ((state_q == pot_if_pkg::ST_TX) && (cnt_q != pot_if_pkg::BIT_ACK))
         begin
            drive_low_q <= ~tx_q[7];
         end
         else
         begin
            // Released for the master's acknowledge and while unselected
            drive_low_q <= 1'b0;
         end
      end
   end

   // Open drain: only ever pulls low, never drives high
   assign sda_o = 1'b0;
   assign sda_oe_n = ~drive_low_q;

   // Guard is sticky from the start on; a fall during the frame cancels the write
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         guard_q <= 1'b0;
      end
      else if (start_evt)
      begin
         guard_q <= ~wp_n_s;
      end
      else
      begin
         guard_q <= guard_q | ~wp_n_s;
      end
   end

   // Instruction, data and pending write captured byte by byte
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         instr_q <= '0;
         data_q <= pot_if_pkg::BYTE_RESET;
         pend_q <= 1'b0;
         rd_req <= 1'b0;
      end
      else
      begin
         rd_req <= 1'b0;
         if (start_evt || stop_evt)
         begin
            pend_q <= 1'b0;
         end
         else if (byte_done && (state_q == pot_if_pkg::ST_INSTR))
         begin
            instr_q <= byte_in;
            rd_req <= pot_if_pkg::is_read(byte_in[7:4]);
            pend_q <= pot_if_pkg::is_short_write(byte_in[7:4]);
         end
         else if (byte_done && (state_q == pot_if_pkg::ST_DATA))
         begin
            data_q <= byte_in;
            pend_q <= ack_d;
         end
      end
   end

   // Command issued at the closing stop; a guarded nonvolatile write is dropped
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         cmd <= '0;
         cmd_valid <= 1'b0;
      end
      else
      begin
         cmd_valid <= stop_evt && pend_q && !nv_blocked;
         if (stop_evt && pend_q && !nv_blocked) // Held until the next issued write
         begin
            cmd <= '{instr: instr_q, data: data_q, nv: pot_if_pkg::is_nv_write(instr_q.opcode)};
         end
      end
   end

   // Programming cycle; once running, the guard pin no longer matters
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         busy_q <= 1'b0;
         busy_cnt_q <= '0;
      end
      else if (busy_q)
      begin
         if (busy_cnt_q == CW'(NV_CYCLES - 1))
         begin
            busy_q <= 1'b0;
            busy_cnt_q <= '0;
         end
         else
         begin
            busy_cnt_q <= busy_cnt_q + 1'b1;
         end
      end
      else if (stop_evt && pend_q && pot_if_pkg::is_nv_write(instr_q.opcode) && !guard_q)
      begin
         busy_q <= 1'b1;
         busy_cnt_q <= '0;
      end
   end

   assign nv_busy = busy_q;
endmodule

/* File: hw/pot_if_pkg.sv */
package pot_if_pkg;

   // Instruction opcodes, upper nibble of the instruction byte
   localparam logic [3:0] OP_GANG_STORED_TO_WIPER = 4'h1;
   localparam logic [3:0] OP_INC_DEC = 4'h2;
   localparam logic [3:0] OP_GANG_WIPER_TO_STORED = 4'h8;
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'hA;
   localparam logic [3:0] OP_RD_STORED = 4'hB;
   localparam logic [3:0] OP_WR_STORED = 4'hC;
   localparam logic [3:0] OP_XFR_STORED_TO_WIPER = 4'hD;
   localparam logic [3:0] OP_XFR_WIPER_TO_STORED = 4'hE;

   // Bit counter positions within one byte plus its acknowledge clock
   localparam logic [3:0] BIT_LAST_DATA = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_FIRST = 4'h0;

   // Line levels seen by the sampler
   localparam logic SDA_ACK_LEVEL = 1'b0;

   // Nonvolatile programming time and its cycle count at the reference clock
   localparam int NV_PROGRAM_TIME_US = 5000;
   localparam int REF_CLK_KHZ = 25000;
   // Longest time, so the division rounds down
   localparam int NV_PROGRAM_CYCLES = (NV_PROGRAM_TIME_US * REF_CLK_KHZ) / 1000;

   // Reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] SYNC_RESET = 4'b1110;

   // Instruction byte layout, msb first
   typedef struct packed {
      logic [3:0] opcode;
      logic setting_select_hi;
      logic setting_select_lo;
      logic [1:0] pot_select;
   } instr_t;

   // Command handed to the register and storage logic
   typedef struct packed {
      instr_t instr;
      logic [7:0] data;
      logic nv;
   } pot_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_INSTR = 3'b010,
      ST_DATA = 3'b011,
      ST_TX = 3'b100,
      ST_WAIT_STOP = 3'b101
   } link_state_t;

   // Instructions that end in a nonvolatile programming cycle
   function automatic logic is_nv_write(input logic [3:0] op);
      return (op == OP_WR_STORED) || (op == OP_XFR_WIPER_TO_STORED) || (op == OP_GANG_WIPER_TO_STORED);
   endfunction

   // Instructions whose third byte the device sends
   function automatic logic is_read(input logic [3:0] op);
      return (op == OP_RD_WIPER) || (op == OP_RD_STORED);
   endfunction

   // Writes that carry a data byte from the master
   function automatic logic is_data_write(input logic [3:0] op);
      return (op == OP_WR_WIPER) || (op == OP_WR_STORED);
   endfunction

   // Two-byte writes that finish with the instruction byte
   function automatic logic is_short_write(input logic [3:0] op);
      return (op == OP_GANG_STORED_TO_WIPER) || (op == OP_INC_DEC) || (op == OP_GANG_WIPER_TO_STORED)
         || (op == OP_XFR_STORED_TO_WIPER) || (op == OP_XFR_WIPER_TO_STORED);
   endfunction

endpackage

/* File: hw/sync2.sv */
`timescale 1ns/10ps
module sync2 #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   // Two flops; the first is read by the second only
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         meta_q <= RESET_VAL;
         q <= RESET_VAL;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

/* File: hw/scl_bit_sampler.sv */
`timescale 1ns/10ps
module scl_bit_sampler (
   input wire logic scl,
   input wire logic resetn,
   input wire logic sda_i,
   output logic bit_q,
   output logic bit_tog_q
);
   logic rst_meta_q;
   logic rst_q;

   // Reset carried into the serial clock domain; only settles once the clock runs
   always_ff @(posedge scl)
   begin
      rst_meta_q <= resetn;
      rst_q <= rst_meta_q;
   end

   // Each rising edge captures one bit; the toggle tells the other domain it is new
   always_ff @(posedge scl)
   begin
      if (!rst_q)
      begin
         bit_q <= 1'b1;
         bit_tog_q <= 1'b0;
      end
      else
      begin
         bit_q <= sda_i;
         bit_tog_q <= ~bit_tog_q;
      end
   end
endmodule

/* File: dv/pot_link_slave_props.sv */
`timescale 1ns/10ps
module pot_link_slave_props #(
   parameter int NV_CYCLES = 200
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic scl,
   input wire logic sda_i,
   input wire logic sda_oe_n,
   input wire logic rd_req,
   input wire pot_if_pkg::pot_cmd_t cmd,
   input wire logic cmd_valid,
   input wire logic nv_busy
);
   logic seen_start_q;
   int stop_age_q;
   int busy_cnt_q;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // Start seen on the raw lines; the device may only act after one
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         seen_start_q <= 1'h0;
      else if (scl && $fell(sda_i))
         seen_start_q <= 1'h1;
   end

   // Cycles since the last stop, saturating so it never wraps
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         stop_age_q <= 1000;
      else if (scl && $rose(sda_i))
         stop_age_q <= 0;
      else if (stop_age_q < 1000)
         stop_age_q <= stop_age_q + 1;
   end

   // Length of the current programming run
   always_ff @(posedge ref_clk)
   begin
      if (!resetn || !nv_busy)
         busy_cnt_q <= 0;
      else
         busy_cnt_q <= busy_cnt_q + 1;
   end

   sequence scl_held_high;
      scl ##1 scl;
   endsequence

   sequence nv_issue;
      cmd_valid && cmd.nv;
   endsequence

   a_quiet_release: assert property ($rose(resetn) |-> sda_oe_n && !cmd_valid && !nv_busy && !rd_req)
      else $error("outputs not quiet after reset");
   a_idle_before_start: assert property (!seen_start_q |-> sda_oe_n)
      else $error("data line pulled before any start");
   a_steady_high: assert property (scl_held_high |-> $stable(sda_oe_n))
      else $error("data drive changed while clock high");
   a_pull_clk_low: assert property ($fell(sda_oe_n) |-> !scl)
      else $error("data pulled while clock high");
   a_busy_released: assert property (nv_busy |-> sda_oe_n)
      else $error("data pulled during programming");
   a_nv_starts_busy: assert property (nv_issue |-> ##[0:1] nv_busy)
      else $error("nonvolatile command without programming");
   a_busy_bound: assert property (busy_cnt_q <= NV_CYCLES)
      else $error("programming longer than allowed");
   a_cmd_at_stop: assert property (cmd_valid |-> stop_age_q <= 10)
      else $error("command issued away from a stop");
   a_rd_single: assert property (rd_req |=> !rd_req [*8])
      else $error("read request not a single pulse");
   a_cmd_held: assert property ($changed(cmd) |-> cmd_valid)
      else $error("command fields changed without issue");
endmodule

bind pot_link_slave pot_link_slave_props #(.NV_CYCLES(NV_CYCLES)) props (.ref_clk(ref_clk), .resetn(resetn),
   .scl(scl), .sda_i(sda_i), .sda_oe_n(sda_oe_n), .rd_req(rd_req), .cmd(cmd), .cmd_valid(cmd_valid),
   .nv_busy(nv_busy));

/* File: dv/bus_master_model.sv */
`timescale 1ns/10ps
module bus_master_model #(
   parameter int QTR = 10
) (
   input wire logic lclk,
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   // Idle bus: clock parked high, data released to the pull-up
   initial
   begin
      scl = 1'h1;
      sda_pull = 1'h0;
   end

   // One phase of the wire; kept above the shortest clock phase
   task automatic pause();
      repeat (QTR) @(posedge lclk);
      #2;
   endtask

   // Short clock burst in reset so the bit sampler clears
   task automatic wake();
      repeat (4)
      begin
         @(posedge lclk);
         #2;
         scl = 1'h0;
         @(posedge lclk);
         #2;
         scl = 1'h1;
      end
   endtask

   // Opened only from an idle bus, data falls with clock high
   task automatic start();
      pause();
      sda_pull = 1'h1;
      pause();
      scl = 1'h0;
   endtask

   // Data rises with clock high, bus left idle
   task automatic stop();
      sda_pull = 1'h1;
      pause();
      scl = 1'h1;
      pause();
      sda_pull = 1'h0;
      pause();
   endtask

   // Data changes only while the clock is low
   task automatic clock_bit(input logic b, output logic seen);
      sda_pull = !b;
      pause();
      scl = 1'h1;
      pause();
      seen = sda;
      scl = 1'h0;
      pause();
   endtask

   // Msb first, ninth clock carries the acknowledge either way
   task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack_in);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         clock_bit(tx[i], s);
         rx[i] = s;
      end
      clock_bit(!ack_out, s);
      ack_in = !s;
   endtask
endmodule

/* File: dv/test_two_wire_pot_slave_interface.sv */
`timescale 1ns/10ps
module test_two_wire_pot_slave_interface;
   localparam int NV_SIM = 400;
   localparam logic [3:0] TYPE_ID = 4'h3; // Arbitrary type code for this run
   localparam logic [3:0] STRAP = 4'h6;
   localparam logic [7:0] ME = {TYPE_ID, STRAP};
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] instr;
      logic [7:0] data;
      logic three;
      logic wp;
      logic sel;
      logic issue;
      logic nv;
   } row_t;
   logic ref_clk = 1'h0;
   logic lclk = 1'h0;
   logic resetn = 1'h0;
   logic wp_n = 1'h1;
   logic [7:0] rd_data = 8'h00;
   logic [3:0] strap = STRAP;
   logic scl, sda_pull, sda_o, sda_oe_n, rd_req, cmd_valid, nv_busy, ack;
   logic [7:0] rx, last;
   pot_if_pkg::pot_cmd_t cmd, c;
   row_t r;
   int mismatches = 0;
   int num_checks = 0;
   int rd_seen = 0;
   int r0;
   int c0;
   int cmd_seen = 0;
   logic [7:0] rd_ops [2] = '{8'h91, 8'hB6};
   // Frames: address, instruction, data, three-byte, guard, selected, issued, nonvolatile
   row_t rows [12] = '{
      '{ME, 8'hA1, 8'h2D, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0},
      '{8'hC6, 8'hA1, 8'h2D, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
      '{8'h37, 8'hA1, 8'h2D, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
      '{8'h3E, 8'hA1, 8'h2D, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
      '{ME, 8'hD5, 8'h00, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0},
      '{ME, 8'h21, 8'h00, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0},
      '{ME, 8'h14, 8'h00, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0},
      '{ME, 8'hC9, 8'h3A, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1},
      '{ME, 8'hE5, 8'h00, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1},
      '{ME, 8'h88, 8'h00, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1},
      '{ME, 8'hC1, 8'h11, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0},
      '{ME, 8'hE4, 8'h00, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0}
   };
   // Open-drain line with pull-up
   wire sda = !(sda_pull || (!sda_oe_n && !sda_o));

   // Reference clock, and the unrelated link base clock
   always #20 ref_clk = !ref_clk;
   always #16 lclk = !lclk;

   pot_link_slave #(.DEVICE_TYPE_ID(TYPE_ID), .NV_CYCLES(NV_SIM)) dut (.ref_clk(ref_clk), .resetn(resetn),
      .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .strap_addr_bit3(strap[3]),
      .strap_addr_bit2(strap[2]), .strap_addr_bit1(strap[1]), .strap_addr_bit0(strap[0]), .wp_n(wp_n),
      .rd_data(rd_data), .rd_req(rd_req), .cmd(cmd), .cmd_valid(cmd_valid), .nv_busy(nv_busy));
   bus_master_model #(.QTR(10)) master (.lclk(lclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

   // Count read requests and issued commands seen by the storage side
   always @(posedge ref_clk)
   begin
      if (rd_req === 1'h1)
         rd_seen++;
      if (cmd_valid === 1'h1)
      begin
         cmd_seen++;
         c = cmd;
      end
   end

   task automatic check(input string what, input logic [16:0] exp, input logic [16:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic drive(input logic wp, input logic [7:0] rd);
      @(posedge ref_clk);
      #2;
      wp_n = wp;
      rd_data = rd;
   endtask

   task automatic send(input logic [7:0] b, input logic exp, input string what);
      master.xfer(b, 1'h0, rx, ack);
      check(what, exp, ack);
   endtask

   // Issue lands inside the stop itself, so pulses are counted from before it
   task automatic wait_cmd();
      repeat (40) @(posedge ref_clk);
      #1;
   endtask

   task automatic wait_idle();
      int n = 0;
      while (nv_busy !== 1'h0 && n < NV_SIM + 50)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (nv_busy !== 1'h0)
      begin
         mismatches++;
         $display("BAD programming end expected 0 seen %b", nv_busy);
         end_sim();
      end
   endtask

   initial
   begin
      fork
         master.wake();
         repeat (8) @(posedge ref_clk);
      join
      check("reset outputs", 17'h0008, {sda_oe_n, cmd_valid, nv_busy, rd_req});
      check("reset command", 17'h0_0000, cmd);
      #2;
      resetn = 1'h1;
      // The sampler leaves reset only on link clock edges, so give it some before any frame
      master.wake();
      repeat (25000) @(posedge ref_clk);
      foreach (rows[i])
      begin
         r = rows[i];
         drive(r.wp, rd_data);
         master.start();
         send(r.addr, r.sel, "address ack");
         send(r.instr, r.sel, "instruction ack");
         if (r.three)
            send(r.data, r.sel && r.wp, "data ack");
         c0 = cmd_seen;
         master.stop();
         wait_cmd();
         check("command issued", r.issue, cmd_seen - c0);
         if (r.issue && r.three)
            last = r.data;
         if (r.issue)
            check("command", {r.instr, last, r.nv}, c);
         check("programming", r.issue && r.nv, nv_busy);
         wait_idle();
      end
      // Poll while programming; a late guard drop must not stop it
      drive(1'h1, rd_data);
      master.start();
      send(ME, 1'h1, "address ack");
      send(8'hC0, 1'h1, "instruction ack");
      send(8'h15, 1'h1, "data ack");
      master.stop();
      master.start();
      send(ME, 1'h0, "poll while busy");
      master.stop();
      drive(1'h0, rd_data);
      repeat (4) @(posedge ref_clk);
      #1;
      check("programming after guard", 1'h1, nv_busy);
      wait_idle();
      drive(1'h1, rd_data);
      master.start();
      send(ME, 1'h1, "poll when done");
      master.stop();
      // Guard falls after the start: the pending write is dropped
      master.start();
      send(ME, 1'h1, "address ack");
      send(8'hC2, 1'h1, "instruction ack");
      drive(1'h0, rd_data);
      send(8'h44, 1'h0, "guarded data ack");
      c0 = cmd_seen;
      master.stop();
      wait_cmd();
      check("guarded command", 1'h0, cmd_seen - c0);
      check("guarded programming", 1'h0, nv_busy);
      // Reads repeat while acknowledged, then fall silent
      foreach (rd_ops[k])
      begin
         drive(1'h1, rd_ops[k] ^ 8'h3C);
         r0 = rd_seen;
         master.start();
         send(ME, 1'h1, "address ack");
         send(rd_ops[k], 1'h1, "instruction ack");
         check("read request", 17'h0001, rd_seen - r0);
         master.xfer(8'hFF, 1'h1, rx, ack);
         check("read byte", rd_data, rx);
         master.xfer(8'hFF, 1'h0, rx, ack);
         check("read byte again", rd_data, rx);
         master.xfer(8'hFF, 1'h0, rx, ack);
         check("after refusal", 17'h00FF, rx);
         master.stop();
      end
      end_sim();
   end
endmodule
